/* File: src/nfd_top.sv */
// Purpose: one die of a 16-bit NOR flash, seen from its bus pins
// Assumes: all pins asynchronous to clk; host holds them while strobing
// Notes:   array smaller than the map aliases on the low address bits
`timescale 1ns/1ns
`include "nfd_map.svh"
module nfd_top #(
	parameter int ADDR_W      = 26,
	parameter int MEM_AW      = 12,
	parameter int PARAM_WORDS = `NFD_PARAM_KBYTE * `NFD_BYTES_PER_KBYTE
		/ `NFD_BYTES_PER_WORD,
	parameter int MAIN_WORDS  = `NFD_MAIN_KBYTE * `NFD_BYTES_PER_KBYTE
		/ `NFD_BYTES_PER_WORD,
	parameter int NUM_PARAM   = `NFD_PARAM_COUNT,
	parameter int PROG_CYCLES = `NFD_PROG_CYCLES,
	parameter bit BOOT_TOP    = 1'b0,
	parameter bit DUAL_DIE    = 1'b1,
	parameter bit DIE_ID      = 1'b0
) (
	input  wire logic                 clk,
	input  wire logic                 rst_n,
	input  wire logic                 shared_die_select_n,
	input  wire logic                 out_en_n,
	input  wire logic                 wr_en_n,
	input  wire logic                 addr_valid_n,
	input  wire logic                 burst_clk,
	input  wire logic                 program_supply_lockout_level,
	input  wire logic [ADDR_W-1:0]    addr,
	input  wire logic [`NFD_DQ_W-1:0] dq_i,
	output logic      [`NFD_DQ_W-1:0] dq_o,
	output logic                      dq_oe,
	output logic                      wait_o,
	output logic                      wait_oe
);
	localparam int DIE_AW = ADDR_W - 1;
	localparam int DW     = `NFD_DQ_W;
	localparam int SW     = `NFD_CTL_PINS + ADDR_W + DW;
	localparam int LW     = `NFD_RCR_LAT_MSB - `NFD_RCR_LAT_LSB + 1;
	localparam logic [DIE_AW-1:0] PW_M = DIE_AW'(PARAM_WORDS - 1);
	localparam logic [DIE_AW-1:0] MW_M = DIE_AW'(MAIN_WORDS - 1);
	localparam logic [SW-1:0] PIN_IDLE = {4'hf, 2'h0, {(ADDR_W + DW){1'b0}}};

	// refuse geometries the block arithmetic cannot serve
	if (NUM_PARAM * PARAM_WORDS != MAIN_WORDS
		|| (MAIN_WORDS & (MAIN_WORDS - 1)) != 0
		|| (PARAM_WORDS & (PARAM_WORDS - 1)) != 0
		|| $clog2(MAIN_WORDS) >= DIE_AW || DIE_AW < DW
		|| MEM_AW > DIE_AW || MEM_AW < 1) begin : g_bad_cfg
		$error("nfd_top: unsupported geometry");
	end

	////////////////////////////////////////////////////////////////////////
	// pin synchronisers, three stages, change taken when two agree
	logic [SW-1:0]     pin_raw;
	logic [SW-1:0]     s1_q, s1_d, s2_q, s2_d, s3_q, s3_d, flt_q, flt_d;
	logic              we_prev_q, we_prev_d, bclk_prev_q, bclk_prev_d;
	logic              f_ce_n, f_oe_n, f_we_n, f_adv_n, f_bclk, f_lock;
	logic              f_die;
	logic [DIE_AW-1:0] f_a;
	logic [DW-1:0]     f_dq;

	assign pin_raw = {shared_die_select_n, out_en_n, wr_en_n, addr_valid_n,
		burst_clk, program_supply_lockout_level, addr, dq_i};
	assign {f_ce_n, f_oe_n, f_we_n, f_adv_n, f_bclk, f_lock, f_die, f_a,
		f_dq} = flt_q;

	// next values of the synchroniser chain and edge memories
	always_comb begin
		s1_d = pin_raw;
		s2_d = s1_q;
		s3_d = s2_q;
		flt_d = (s2_q & s3_q) | (flt_q & (s2_q ^ s3_q));
		we_prev_d = f_we_n;
		bclk_prev_d = f_bclk;
	end

	// synchroniser registers
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			s1_q <= PIN_IDLE;
			s2_q <= PIN_IDLE;
			s3_q <= PIN_IDLE;
			flt_q <= PIN_IDLE;
			we_prev_q <= 1'b1;
			bclk_prev_q <= 1'b0;
		end else begin
			s1_q <= s1_d;
			s2_q <= s2_d;
			s3_q <= s3_d;
			flt_q <= flt_d;
			we_prev_q <= we_prev_d;
			bclk_prev_q <= bclk_prev_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// die selection and block geometry
	logic              sel;
	logic              in_param;
	logic [DIE_AW-1:0] blk_mask, blk_base, blk_last;

	nfd_die_sel #(
		.DUAL_DIE (DUAL_DIE),
		.DIE_ID   (DIE_ID)
	) u_die_sel (
		.die_select_n (f_ce_n),
		.die_bit      (f_die),
		.selected     (sel)
	);

	// parameter region is one main block at the top or bottom
	assign in_param = BOOT_TOP ? ((f_a & ~MW_M) == ~MW_M)
		: ((f_a & ~MW_M) == '0);
	assign blk_mask = in_param ? PW_M : MW_M;
	assign blk_base = f_a & ~blk_mask;
	assign blk_last = f_a | blk_mask;

	////////////////////////////////////////////////////////////////////////
	// sequencer and its array port
	nfd_wsm_if #(.AW(DIE_AW)) wif ();
	logic [DW-1:0] mem [2**MEM_AW];

	nfd_wsm #(
		.AW          (DIE_AW),
		.PROG_CYCLES (PROG_CYCLES)
	) u_wsm (
		.clk   (clk),
		.rst_n (rst_n),
		.w     (wif)
	);

	assign wif.prog_addr = f_a;
	assign wif.prog_data = f_dq;
	assign wif.erase_base = blk_base;
	assign wif.erase_last = blk_last;
	assign wif.lockout = f_lock;

	// program only clears bits, erase sets the whole word
	always_ff @(posedge clk) begin
		if (wif.mem_we) begin
			mem[wif.mem_addr[MEM_AW-1:0]] <= wif.mem_erase ? `NFD_ERASED_WORD
				: (mem[wif.mem_addr[MEM_AW-1:0]] & wif.mem_data);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// command interface
	nfd_pkg::nfd_cmd_st_t  cmd_q, cmd_d;
	nfd_pkg::nfd_rd_mode_t rd_q, rd_d;
	logic [DW-1:0]         cfg_q, cfg_d;
	logic [`NFD_CMD_W-1:0] cmd_code;
	logic                  we_rise, hit_w, prog_ok, erase_ok;
	logic                  set_perr, set_eerr, set_verr, clr_sr;

	assign cmd_code = f_dq[`NFD_CMD_W-1:0];
	assign we_rise = sel & f_we_n & ~we_prev_q;
	assign hit_w = (f_a >= wif.held_base) & (f_a <= wif.held_last);
	assign prog_ok = ~wif.running & ~wif.prog_susp
		& (~wif.erase_susp | ~hit_w);
	assign erase_ok = ~wif.running & ~wif.prog_susp & ~wif.erase_susp;

	// decode of each write strobe
	always_comb begin
		cmd_d = cmd_q;
		rd_d = rd_q;
		cfg_d = cfg_q;
		set_perr = 1'b0;
		set_eerr = 1'b0;
		set_verr = 1'b0;
		clr_sr = 1'b0;
		wif.start_prog = 1'b0;
		wif.start_erase = 1'b0;
		wif.suspend = 1'b0;
		wif.resume = 1'b0;
		if (we_rise) begin
			unique case (cmd_q)
			nfd_pkg::cmd_idle: begin
				case (cmd_code)
				`NFD_CMD_READ_ARRAY:   rd_d = nfd_pkg::rd_array;
				`NFD_CMD_READ_STATUS:  rd_d = nfd_pkg::rd_status;
				`NFD_CMD_CLEAR_STATUS: clr_sr = 1'b1;
				`NFD_CMD_PROGRAM: begin
					cmd_d = nfd_pkg::cmd_prog;
					rd_d = nfd_pkg::rd_status;
				end
				`NFD_CMD_ERASE: begin
					cmd_d = nfd_pkg::cmd_erase;
					rd_d = nfd_pkg::rd_status;
				end
				`NFD_CMD_CFG_SETUP:    cmd_d = nfd_pkg::cmd_cfg;
				`NFD_CMD_SUSPEND: begin
					wif.suspend = 1'b1;
					rd_d = nfd_pkg::rd_status;
				end
				`NFD_CMD_CONFIRM: begin
					wif.resume = 1'b1;
					rd_d = nfd_pkg::rd_status;
				end
				default: cmd_d = nfd_pkg::cmd_idle;
				endcase
			end
			nfd_pkg::cmd_prog: begin
				cmd_d = nfd_pkg::cmd_idle;
				if (f_lock) begin
					set_perr = 1'b1;
					set_verr = 1'b1;
				end else if (prog_ok) begin
					wif.start_prog = 1'b1;
				end else begin
					set_perr = 1'b1;
				end
			end
			nfd_pkg::cmd_erase: begin
				cmd_d = nfd_pkg::cmd_idle;
				if (cmd_code != `NFD_CMD_CONFIRM) begin
					set_perr = 1'b1; // bad sequence flags both
					set_eerr = 1'b1;
				end else if (f_lock) begin
					set_eerr = 1'b1;
					set_verr = 1'b1;
				end else if (erase_ok) begin
					wif.start_erase = 1'b1;
				end else begin
					set_eerr = 1'b1;
				end
			end
			nfd_pkg::cmd_cfg: begin
				cmd_d = nfd_pkg::cmd_idle;
				rd_d = nfd_pkg::rd_array;
				if (cmd_code == `NFD_CMD_CFG_CONFIRM) begin
					cfg_d = f_a[DW-1:0];
				end
			end
			endcase
		end
	end

	// command registers, config comes up asynchronous
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cmd_q <= nfd_pkg::cmd_idle;
			rd_q <= nfd_pkg::rd_array;
			cfg_q <= `NFD_RCR_RESET;
		end else begin
			cmd_q <= cmd_d;
			rd_q <= rd_d;
			cfg_q <= cfg_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// status word, sticky errors where a set beats a clear
	logic          perr_q, perr_d, eerr_q, eerr_d, verr_q, verr_d;
	logic [DW-1:0] status_reg;

	// error flags and the assembled status word
	always_comb begin
		perr_d = set_perr | (wif.abort & ~wif.abort_erase)
			| (perr_q & ~clr_sr);
		eerr_d = set_eerr | (wif.abort & wif.abort_erase)
			| (eerr_q & ~clr_sr);
		verr_d = set_verr | wif.abort | (verr_q & ~clr_sr);
		status_reg = '0;
		status_reg[`NFD_SR_READY] = ~wif.running;
		status_reg[`NFD_SR_ESUSP] = wif.erase_susp;
		status_reg[`NFD_SR_EERR] = eerr_q;
		status_reg[`NFD_SR_PERR] = perr_q;
		status_reg[`NFD_SR_VERR] = verr_q;
		status_reg[`NFD_SR_PSUSP] = wif.prog_susp;
	end

	// error registers
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			perr_q <= 1'b0;
			eerr_q <= 1'b0;
			verr_q <= 1'b0;
		end else begin
			perr_q <= perr_d;
			eerr_q <= eerr_d;
			verr_q <= verr_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// read path and burst sequencing
	logic              sync_mode, bclk_rise, b_launch, rd_busy;
	logic              b_act_q, b_act_d, b_wait_q, b_wait_d;
	logic [DIE_AW-1:0] ba_q, ba_d, rd_addr;
	logic [LW-1:0]     lat_q, lat_d;
	logic [DW-1:0]     rd_word, mem_word;

	assign sync_mode = ~cfg_q[`NFD_RCR_ASYNC_BIT];
	assign bclk_rise = f_bclk & ~bclk_prev_q;
	assign rd_addr = sync_mode ? ba_q : f_a;
	assign mem_word = mem[rd_addr[MEM_AW-1:0]];
	// busy or suspended locations answer with status instead of data
	assign rd_busy = wif.running
		| (wif.erase_susp & (rd_addr >= wif.held_base)
		& (rd_addr <= wif.held_last))
		| (wif.prog_susp & (rd_addr == wif.held_prog));

	// word selected for the bus
	always_comb begin
		unique case (rd_q)
		nfd_pkg::rd_array:  rd_word = rd_busy ? status_reg : mem_word;
		nfd_pkg::rd_status: rd_word = status_reg;
		endcase
	end

	// burst: address on a clock edge with valid low, then latency, then data
	always_comb begin
		b_act_d = b_act_q;
		b_wait_d = b_wait_q;
		ba_d = ba_q;
		lat_d = lat_q;
		b_launch = 1'b0;
		if (!sel || !sync_mode) begin
			b_act_d = 1'b0;
			b_wait_d = 1'b0;
		end else if (bclk_rise) begin
			if (!f_adv_n) begin
				b_act_d = 1'b1;
				ba_d = f_a;
				lat_d = cfg_q[`NFD_RCR_LAT_MSB:`NFD_RCR_LAT_LSB];
				b_wait_d = 1'b1;
			end else if (b_act_q) begin
				if (lat_q != '0) begin
					lat_d = lat_q - 1'b1;
				end else begin
					b_launch = 1'b1;
					ba_d = ba_q + 1'b1;
					b_wait_d = 1'b0;
				end
			end
		end
	end

	// burst registers
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			b_act_q <= 1'b0;
			b_wait_q <= 1'b0;
			ba_q <= '0;
			lat_q <= '0;
		end else begin
			b_act_q <= b_act_d;
			b_wait_q <= b_wait_d;
			ba_q <= ba_d;
			lat_q <= lat_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// pin drivers
	logic [DW-1:0] dq_q, dq_d;
	logic          oe_q, oe_d;

	// data follows the address when asynchronous, the clock when bursting
	always_comb begin
		dq_d = dq_q;
		if (!sync_mode || b_launch) begin
			dq_d = rd_word;
		end
		oe_d = sel & ~f_oe_n & f_we_n;
	end

	// output registers
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			dq_q <= '0;
			oe_q <= 1'b0;
		end else begin
			dq_q <= dq_d;
			oe_q <= oe_d;
		end
	end

	assign dq_o = dq_q;
	assign dq_oe = oe_q;
	assign wait_o = b_wait_q;
	assign wait_oe = oe_q;
endmodule : nfd_top

/* File: src/nfd_map.svh */
// Purpose: named constants of the flash die front end
// Assumes: included by bare name wherever a constant is needed
// Notes:   command codes and field positions of the RTL live only here, the tests use literals
`ifndef NFD_MAP_SVH
`define NFD_MAP_SVH

// bus widths and pin group size
`define NFD_DQ_W             16
`define NFD_CMD_W            8
`define NFD_CTL_PINS         6

// command codes taken on the low data byte
`define NFD_CMD_READ_ARRAY   8'hff
`define NFD_CMD_READ_STATUS  8'h70
`define NFD_CMD_CLEAR_STATUS 8'h50
`define NFD_CMD_PROGRAM      8'h40
`define NFD_CMD_ERASE        8'h20
`define NFD_CMD_CONFIRM      8'hd0
`define NFD_CMD_SUSPEND      8'hb0
`define NFD_CMD_CFG_SETUP    8'h60
`define NFD_CMD_CFG_CONFIRM  8'h03

// read configuration layout
`define NFD_RCR_RESET        16'h9800
`define NFD_RCR_ASYNC_BIT    15
`define NFD_RCR_LAT_MSB      13
`define NFD_RCR_LAT_LSB      11

// status word bit positions
`define NFD_SR_READY         7
`define NFD_SR_ESUSP         6
`define NFD_SR_EERR          5
`define NFD_SR_PERR          4
`define NFD_SR_VERR          3
`define NFD_SR_PSUSP         2

// array geometry and timing
`define NFD_PARAM_KBYTE      32
`define NFD_MAIN_KBYTE       128
`define NFD_BYTES_PER_KBYTE  1024
`define NFD_BYTES_PER_WORD   2
`define NFD_PARAM_COUNT      4
`define NFD_PROG_CYCLES      16
`define NFD_ERASED_WORD      16'hffff

`endif

/* File: src/nfd_pkg.sv */
// Purpose: state and mode types of the flash die front end
// Assumes: used through nfd_pkg:: only
// Notes:   wsm state has spare codes, caught by a default
package nfd_pkg;
	typedef enum logic [1:0] {cmd_idle, cmd_prog, cmd_erase, cmd_cfg}
		nfd_cmd_st_t;
	typedef enum logic {rd_array, rd_status} nfd_rd_mode_t;
	typedef enum logic [2:0] {wsm_idle, wsm_prog, wsm_psusp, wsm_erase,
		wsm_esusp, wsm_nest} nfd_wsm_st_t;
endpackage : nfd_pkg

/* File: src/nfd_wsm_if.sv */
// Purpose: link between command logic and the write state machine
// Assumes: one clock, both ends on clk
// Notes:   held_* show the context of a suspended operation
`timescale 1ns/1ns
interface nfd_wsm_if #(
	parameter int AW = 25
);
	logic          start_prog;
	logic          start_erase;
	logic          suspend;
	logic          resume;
	logic          lockout;
	logic [AW-1:0] prog_addr;
	logic [15:0]   prog_data;
	logic [AW-1:0] erase_base;
	logic [AW-1:0] erase_last;
	logic          running;
	logic          erase_susp;
	logic          prog_susp;
	logic          abort;
	logic          abort_erase;
	logic [AW-1:0] held_base;
	logic [AW-1:0] held_last;
	logic [AW-1:0] held_prog;
	logic          mem_we;
	logic          mem_erase;
	logic [AW-1:0] mem_addr;
	logic [15:0]   mem_data;

	modport ctl (output start_prog, start_erase, suspend, resume, lockout,
		prog_addr, prog_data, erase_base, erase_last,
		input running, erase_susp, prog_susp, abort, abort_erase,
		held_base, held_last, held_prog, mem_we, mem_erase, mem_addr,
		mem_data);
	modport wsm (input start_prog, start_erase, suspend, resume, lockout,
		prog_addr, prog_data, erase_base, erase_last,
		output running, erase_susp, prog_susp, abort, abort_erase,
		held_base, held_last, held_prog, mem_we, mem_erase, mem_addr,
		mem_data);
endinterface : nfd_wsm_if

/* File: src/nfd_die_sel.sv */
// Purpose: decide whether this die answers the shared select
// Assumes: inputs already synchronised
// Notes:   single-die build ignores the die bit
`timescale 1ns/1ns
module nfd_die_sel #(
	parameter bit DUAL_DIE = 1'b1,
	parameter bit DIE_ID   = 1'b0
) (
	input  wire logic die_select_n,
	input  wire logic die_bit,
	output logic      selected
);
	// low die bit picks die 0, high die bit picks die 1
	assign selected = ~die_select_n & (~DUAL_DIE | (die_bit == DIE_ID));
endmodule : nfd_die_sel

/* File: src/nfd_wsm.sv */
// Purpose: timed program and block erase sequencer with suspend
// Assumes: start requests only come when the sequencer can take them
// Notes:   program during erase suspend runs nested, then returns
`timescale 1ns/1ns
`include "nfd_map.svh"
module nfd_wsm #(
	parameter int AW          = 25,
	parameter int PROG_CYCLES = `NFD_PROG_CYCLES
) (
	input  wire logic clk,
	input  wire logic rst_n,
	nfd_wsm_if.wsm    w
);
	localparam int CW = $clog2(PROG_CYCLES + 1);
	localparam logic [CW-1:0] PROG_LAST = CW'(PROG_CYCLES - 1);

	// refuse a program time the counter cannot hold
	if (PROG_CYCLES < 1) begin : g_bad_cfg
		$error("nfd_wsm: PROG_CYCLES must be at least one");
	end

	nfd_pkg::nfd_wsm_st_t st_q, st_d;
	logic [CW-1:0]        cnt_q, cnt_d;
	logic [AW-1:0]        ea_q, ea_d, eb_q, eb_d, el_q, el_d, pa_q, pa_d;
	logic [15:0]          pd_q, pd_d;

	////////////////////////////////////////////////////////////////////////
	// sequencing of program and erase
	always_comb begin
		st_d          = st_q;
		cnt_d         = cnt_q;
		ea_d          = ea_q;
		eb_d          = eb_q;
		el_d          = el_q;
		pa_d          = pa_q;
		pd_d          = pd_q;
		w.abort       = 1'b0;
		w.abort_erase = 1'b0;
		w.mem_we      = 1'b0;
		w.mem_erase   = 1'b0;
		w.mem_addr    = pa_q;
		w.mem_data    = pd_q;
		unique case (st_q)
		nfd_pkg::wsm_idle: begin
			if (w.start_prog) begin
				st_d = nfd_pkg::wsm_prog;
				pa_d = w.prog_addr;
				pd_d = w.prog_data;
				cnt_d = '0;
			end else if (w.start_erase) begin
				st_d = nfd_pkg::wsm_erase;
				ea_d = w.erase_base;
				eb_d = w.erase_base;
				el_d = w.erase_last;
			end
		end
		nfd_pkg::wsm_prog, nfd_pkg::wsm_nest: begin
			if (w.lockout) begin
				w.abort = 1'b1;
				st_d = (st_q == nfd_pkg::wsm_nest) ? nfd_pkg::wsm_esusp
					: nfd_pkg::wsm_idle;
			end else if (w.suspend && st_q == nfd_pkg::wsm_prog) begin
				st_d = nfd_pkg::wsm_psusp;
			end else if (cnt_q == PROG_LAST) begin
				w.mem_we = 1'b1;
				st_d = (st_q == nfd_pkg::wsm_nest) ? nfd_pkg::wsm_esusp
					: nfd_pkg::wsm_idle;
			end else begin
				cnt_d = cnt_q + 1'b1;
			end
		end
		nfd_pkg::wsm_psusp: begin
			if (w.resume) begin
				st_d = nfd_pkg::wsm_prog;
			end
		end
		nfd_pkg::wsm_erase: begin
			if (w.lockout) begin
				w.abort = 1'b1;
				w.abort_erase = 1'b1;
				st_d = nfd_pkg::wsm_idle;
			end else if (w.suspend) begin
				st_d = nfd_pkg::wsm_esusp;
			end else begin
				w.mem_we = 1'b1;
				w.mem_erase = 1'b1;
				w.mem_addr = ea_q;
				if (ea_q == el_q) begin
					st_d = nfd_pkg::wsm_idle;
				end else begin
					ea_d = ea_q + 1'b1;
				end
			end
		end
		nfd_pkg::wsm_esusp: begin
			if (w.resume) begin
				st_d = nfd_pkg::wsm_erase;
			end else if (w.start_prog) begin
				st_d = nfd_pkg::wsm_nest;
				pa_d = w.prog_addr;
				pd_d = w.prog_data;
				cnt_d = '0;
			end
		end
		default: st_d = nfd_pkg::wsm_idle;
		endcase
	end

	// sequencer registers
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			st_q <= nfd_pkg::wsm_idle;
			cnt_q <= '0;
			ea_q <= '0;
			eb_q <= '0;
			el_q <= '0;
			pa_q <= '0;
			pd_q <= '0;
		end else begin
			st_q <= st_d;
			cnt_q <= cnt_d;
			ea_q <= ea_d;
			eb_q <= eb_d;
			el_q <= el_d;
			pa_q <= pa_d;
			pd_q <= pd_d;
		end
	end

	// progress seen by the command side
	assign w.running = (st_q == nfd_pkg::wsm_prog)
		| (st_q == nfd_pkg::wsm_erase) | (st_q == nfd_pkg::wsm_nest);
	assign w.erase_susp = (st_q == nfd_pkg::wsm_esusp)
		| (st_q == nfd_pkg::wsm_nest);
	assign w.prog_susp = (st_q == nfd_pkg::wsm_psusp);
	assign w.held_base = eb_q;
	assign w.held_last = el_q;
	assign w.held_prog = pa_q;
endmodule : nfd_wsm

/* File: test/nfd_top_monitor.sv */
// Purpose: pin level checks of one flash die
// Assumes: die 0 of a dual part, bound to nfd_top
// Notes:   pins pass a three flop filter, so eight cycle windows
`timescale 1ns/1ns
module nfd_top_monitor #(
	parameter int ADDR_W = 26
) (
	input wire logic              clk,
	input wire logic              rst_n,
	input wire logic              shared_die_select_n,
	input wire logic              out_en_n,
	input wire logic              wr_en_n,
	input wire logic [ADDR_W-1:0] addr,
	input wire logic [15:0]       dq_o,
	input wire logic              dq_oe,
	input wire logic              wait_o,
	input wire logic              wait_oe
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	////////////////////////////////////////
	// pin states held long enough to pass the filter
	sequence s_desel;
		shared_die_select_n [*8];
	endsequence
	sequence s_other_die;
		addr[ADDR_W-1] [*8];
	endsequence
	sequence s_read;
		(!shared_die_select_n && !out_en_n && wr_en_n
			&& !addr[ADDR_W-1]) [*8];
	endsequence
	////////////////////////////////////////
	// output relations
	a_rst_quiet: assert property ($rose(rst_n) |-> !dq_oe && !wait_oe)
		else $error("pins driven after reset");
	a_rst_data: assert property ($rose(rst_n) |-> dq_o == 16'h0 && !wait_o)
		else $error("outputs not cleared by reset");
	a_oe_pair: assert property (dq_oe == wait_oe)
		else $error("data and wait enables differ");
	a_desel_quiet: assert property (s_desel |-> !dq_oe)
		else $error("data driven while deselected");
	a_desel_nowait: assert property (s_desel |-> !wait_o)
		else $error("wait raised while deselected");
	a_other_die: assert property (s_other_die |-> !dq_oe)
		else $error("die answers the other die bit");
	a_read_drives: assert property (s_read |-> dq_oe)
		else $error("selected die does not drive a read");
	a_oe_gate: assert property (out_en_n [*8] |-> !dq_oe)
		else $error("data driven without output enable");
endmodule : nfd_top_monitor

/* File: test/nfd_host.sv */
// Purpose: host side pin driver for one flash die
// Assumes: pins move only on rising edges of clk
// Notes:   every level but the one clock select and output enable release between tasks is held well past the three flop filter
`timescale 1ns/1ns
module nfd_host #(
	parameter int AW = 17
) (
	input  wire logic        clk,
	output logic             sel_n,
	output logic             oe_n,
	output logic             we_n,
	output logic             adv_n,
	output logic             bclk,
	output logic             lock,
	output logic [AW-1:0]    a,
	output logic [15:0]      d,
	output logic             done,
	input  wire logic [15:0] q
);
	logic [15:0] exp_q [$];
	////////////////////////////////////////
	// idle pins from time zero, host clock stands low
	initial begin
		{sel_n, oe_n, we_n, adv_n, bclk, lock, done} = 7'h78;
		a = '0;
		d = '0;
	end
	task automatic step(input int n);
		repeat (n) @(posedge clk);
	endtask : step
	// one write strobe cycle of twelve clocks
	task automatic wr(input logic [AW-1:0] ad, input logic [15:0] dt);
		@(posedge clk);
		{sel_n, we_n} <= 2'b00;
		a <= ad;
		d <= dt;
		step(6);
		we_n <= 1'b1;
		step(6);
		sel_n <= 1'b1;
	endtask : wr
	// note the expectation, flag the watcher for one clock
	task automatic mark(input logic [15:0] e);
		exp_q.push_back(e);
		done <= 1'b1;
		step(1);
		done <= 1'b0;
	endtask : mark
	task automatic rd(input logic [AW-1:0] ad, input logic [15:0] e,
		input bit p);
		@(posedge clk);
		{sel_n, oe_n} <= 2'b00;
		a <= ad;
		step(8);
		if (p)
			mark(e);
		{sel_n, oe_n} <= 2'b11;
	endtask : rd
	// command pair, bounded poll for ready, status check
	task automatic op(input logic [AW-1:0] ad, input logic [15:0] c, dt,
		st);
		wr(ad, c);
		wr(ad, dt);
		@(posedge clk);
		{sel_n, oe_n} <= 2'b00;
		step(6);
		for (int i = 0; i < 80 && q[7] !== 1'b1; i++)
			step(1);
		rd(ad, st, 1'b1);
		wr(ad, 16'h00ff);
	endtask : op
	task automatic rise();
		@(posedge clk);
		bclk <= 1'b1;
		step(6);
		bclk <= 1'b0;
		step(6);
	endtask : rise
	task automatic burst(input logic [AW-1:0] ad);
		@(posedge clk);
		{sel_n, oe_n, adv_n} <= 3'b000;
		a <= ad;
		step(6);
		rise();
		adv_n <= 1'b1;
	endtask : burst
	task automatic beat(input logic [15:0] e);
		rise();
		mark(e);
	endtask : beat
endmodule : nfd_host

/* File: test/nfd_top_bench.sv */
// Purpose: self checking bench of one flash die
// Assumes: die 0, bottom parameter blocks of four words
// Notes:   main blocks of sixteen words keep erase short
`timescale 1ns/1ns
module nfd_top_bench;
	localparam int AW = 17;
	logic          clk = 1'b0;
	logic          rst_n = 1'b0;
	logic          sel_n, oe_n, we_n, adv_n, bclk, lock, done;
	logic          dq_oe, wait_o, wait_oe;
	logic [AW-1:0] a;
	logic [15:0]   d, q, v, w;
	logic [AW-1:0] blk [3] = '{17'h10, 17'h04, 17'h08};
	int            errors = 0;
	int            comparisons = 0;
	always #5 clk = ~clk;
	nfd_top #(.ADDR_W(AW), .PARAM_WORDS(4), .MAIN_WORDS(16),
		.PROG_CYCLES(40)) u_nfd_top (.clk(clk), .rst_n(rst_n),
		.shared_die_select_n(sel_n), .out_en_n(oe_n), .wr_en_n(we_n),
		.addr_valid_n(adv_n), .burst_clk(bclk),
		.program_supply_lockout_level(lock), .addr(a), .dq_i(d),
		.dq_o(q), .dq_oe(dq_oe), .wait_o(wait_o), .wait_oe(wait_oe));
	nfd_host #(.AW(AW)) u_nfd_host (.clk(clk), .sel_n(sel_n),
		.oe_n(oe_n), .we_n(we_n), .adv_n(adv_n), .bclk(bclk),
		.lock(lock), .a(a), .d(d), .done(done), .q(q));
	////////////////////////////////////////
	task automatic chk(input string n, input logic [15:0] s, e);
		comparisons++;
		if (s !== e) begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	task automatic end_sim();
		$display("comparisons %0d errors %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : end_sim
	// compare each flagged result with the oldest note
	always @(posedge clk) begin
		if (done === 1'b1 && u_nfd_host.exp_q.size() > 0)
			chk("dq_o", q, u_nfd_host.exp_q.pop_front());
	end
	// cut a hang short
	initial begin
		repeat (30000) @(posedge clk);
		errors++;
		end_sim();
	end
	// main sequence
	initial begin
		v = 16'($urandom(32'h71b3));
		w = 16'($urandom());
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		foreach (blk[i])
			u_nfd_host.op(blk[i], 16'h0020, 16'h00d0, 16'h0080);
		u_nfd_host.op(17'h08, 16'h0040, w, 16'h0080);
		u_nfd_host.op(17'h11, 16'h0040, v, 16'h0080);
		u_nfd_host.op(17'h04, 16'h0020, 16'h00d0, 16'h0080);
		u_nfd_host.rd(17'h04, 16'hffff, 1'b1);
		u_nfd_host.rd(17'h07, 16'hffff, 1'b1);
		u_nfd_host.rd(17'h08, w, 1'b1);
		u_nfd_host.rd(17'h1f, 16'hffff, 1'b1);
		u_nfd_host.rd(17'h11, v, 1'b1);
		// suspend a long program, read around it, then resume it
		u_nfd_host.wr(17'h12, 16'h0040);
		u_nfd_host.wr(17'h12, 16'h0000);
		u_nfd_host.wr(17'h0, 16'h00b0);
		u_nfd_host.rd(17'h12, 16'h0084, 1'b1);
		u_nfd_host.wr(17'h0, 16'h00ff);
		u_nfd_host.rd(17'h11, v, 1'b1);
		u_nfd_host.rd(17'h12, 16'h0084, 1'b1);
		u_nfd_host.op(17'h12, 16'h00d0, 16'h0070, 16'h0080);
		u_nfd_host.rd(17'h12, 16'h0000, 1'b1);
		u_nfd_host.lock <= 1'b1;
		u_nfd_host.op(17'h14, 16'h0040, 16'h0000, 16'h0098);
		u_nfd_host.wr(17'h0, 16'h0050);
		u_nfd_host.lock <= 1'b0;
		u_nfd_host.wr(17'h0, 16'h0070);
		u_nfd_host.rd(17'h0, 16'h0080, 1'b1);
		u_nfd_host.wr(17'h0, 16'h00ff);
		u_nfd_host.rd(17'h14, 16'hffff, 1'b1);
		u_nfd_host.rd(17'h10010, 16'h0000, 1'b0);
		#1;
		chk("dq_oe", {15'h0, dq_oe}, 16'h0000);
		u_nfd_host.wr(17'h0, 16'h0060);
		u_nfd_host.wr(17'h0, 16'h0003);
		u_nfd_host.burst(17'h10);
		#1;
		chk("wait_o", {15'h0, wait_o}, 16'h0001);
		u_nfd_host.beat(16'hffff);
		u_nfd_host.beat(v);
		#1;
		chk("wait_o", {15'h0, wait_o}, 16'h0000);
		end_sim();
	end
endmodule : nfd_top_bench
bind nfd_top nfd_top_monitor #(.ADDR_W(ADDR_W)) u_nfd_top_monitor (
	.clk(clk), .rst_n(rst_n), .shared_die_select_n(shared_die_select_n),
	.out_en_n(out_en_n), .wr_en_n(wr_en_n), .addr(addr), .dq_o(dq_o),
	.dq_oe(dq_oe), .wait_o(wait_o), .wait_oe(wait_oe));
